// ==== rtl/ics_pkg.sv ====
// Purpose: Shared constants and types for the I/O channel slave interface
// Assumes: sys_clk at 10 MHz; all channel pins are asynchronous to it
// Notes:   Times are kept in their own unit and turned into cycle counts here
package ics_pkg;

	// ---------------------------------------------------------------
	// Clock and timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS       = 100;
	localparam int RESET_CLEAR_NS      = 10000;
	localparam int ACCESS_CLEAR_NS     = 3000;
	localparam int RESET_CLEAR_CYC     = RESET_CLEAR_NS / CLK_PERIOD_NS;
	localparam int ACCESS_CLEAR_CYC    = ACCESS_CLEAR_NS / CLK_PERIOD_NS;

	// ---------------------------------------------------------------
	// Channel widths
	// ---------------------------------------------------------------
	localparam int ADDR_W              = 12;
	localparam int DATA_W              = 8;
	localparam int IRQ_LINES           = 4;

	// ---------------------------------------------------------------
	// Default decode addresses and reset values
	// ---------------------------------------------------------------
	localparam logic [11:0] STATUS_ADDR_DEF = 12'h000;
	localparam logic [11:0] WCLR_ADDR_DEF   = 12'h001;
	localparam logic [11:0] DATA_ADDR_DEF   = 12'h002;
	localparam logic [7:0]  DATA_RST        = 8'h00;
	localparam logic [1:0]  IRQ_LINE_DEF    = 2'h0;

	// Clearing method for the held interrupt
	typedef enum logic [1:0] {
		ICS_CLR_RESET,
		ICS_CLR_READ,
		ICS_CLR_WRITE
	} ics_clr_mode_t;

	// Synchronised view of the master's side of the channel
	typedef struct packed {
		logic        strobe;
		logic        write;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} ics_req_t;

	// Slave drive onto the channel (enables are active low)
	typedef struct packed {
		logic       ack_n;
		logic       ack_oe_n;
		logic [7:0] data;
		logic       data_oe_n;
		logic [3:0] irq_n;
		logic [3:0] irq_oe_n;
	} ics_drv_t;

endpackage : ics_pkg

// ==== rtl/ics_slave.sv ====
// Purpose: Slave end of the ribbon-cable I/O expansion channel
// Assumes: Master owns every transfer; all pins sampled through two flops
// Notes:   One interrupt source, routed to a selectable line, cleared the way clr_mode selects or by channel reset
`timescale 1ns/1ps

// Overview of operation
// - Strobe answered by acknowledge, fully interlocked
// - Request service on one of four lines
// - Hold interrupt low until cleared
// - Status byte readable at fixed address
// - Reset clear releases line within ten microseconds
// - Reset wipes status history
// - Read of status address releases within 3us
// - Write of clear address releases within 3us
// - Channel reset forces initial state
module ics_slave
	import ics_pkg::*;
#(
	parameter logic [11:0] STATUS_ADDR = ics_pkg::STATUS_ADDR_DEF,
	parameter logic [11:0] WCLR_ADDR   = ics_pkg::WCLR_ADDR_DEF,
	parameter logic [11:0] DATA_ADDR   = ics_pkg::DATA_ADDR_DEF
) (
	// Clock and reset
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	// Channel inputs from the master
	input  wire logic                  xfer_strobe_n,
	input  wire logic                  write_sel_n,
	input  wire logic                  channel_reset_n,
	input  wire logic [11:0]           slave_addr,
	input  wire logic [7:0]            byte_lane_in,
	// Channel outputs (enables low while driving)
	output logic                       xfer_ack_n,
	output logic                       xfer_ack_oe_n,
	output logic      [7:0]            byte_lane_out,
	output logic                       byte_lane_oe_n,
	output logic      [3:0]            irq_lines_n,
	output logic      [3:0]            irq_lines_oe_n,
	// Local side
	input  wire logic                  event_pulse,
	input  wire logic [6:0]            cause_in,
	input  wire ics_pkg::ics_clr_mode_t clr_mode,
	input  wire logic [1:0]            irq_line_sel,
	output logic      [7:0]            rx_data,
	output logic                       rx_valid
);
	import ics_pkg::*;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	logic [22:0] pins_s;
	ics_req_t    req;
	logic        chan_rst;

	// Strobe, channel reset and write select idle high, so they come up inactive
	ics_sync #(.W(23), .RST_VAL(23'h700000)) u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.async_in ({xfer_strobe_n, channel_reset_n, write_sel_n, slave_addr, byte_lane_in}),
		.sync_out (pins_s)
	);

	always_comb begin
		req.strobe = ~pins_s[22];
		chan_rst   = ~pins_s[21];
		req.write  = ~pins_s[20];
		req.addr   = pins_s[19:8];
		req.wdata  = pins_s[7:0];
	end

	// ---------------------------------------------------------------
	// Handshake state machine
	// ---------------------------------------------------------------
	typedef enum logic [1:0] { ICS_IDLE, ICS_SETTLE, ICS_ACK } ics_state_t;

	ics_state_t state_q, state_d;
	ics_drv_t   drv_q, drv_d;
	logic       pend_q, pend_d;
	logic [6:0] cause_q, cause_d;
	logic [1:0] line_q, line_d;
	logic [7:0] rx_data_q, rx_data_d;
	logic       rx_valid_q, rx_valid_d;
	logic       hit, clr_hit;

	// Address is sampled one cycle after strobe so the synchronised bus has settled
	always_comb begin
		hit     = (req.addr == STATUS_ADDR) || (req.addr == WCLR_ADDR) || (req.addr == DATA_ADDR);
		clr_hit = (clr_mode == ICS_CLR_READ  && !req.write && req.addr == STATUS_ADDR) ||
		          (clr_mode == ICS_CLR_WRITE &&  req.write && req.addr == WCLR_ADDR);
	end

	always_comb begin
		state_d    = state_q;
		drv_d      = drv_q;
		pend_d     = pend_q;
		cause_d    = cause_q;
		line_d     = line_q;
		rx_data_d  = rx_data_q;
		rx_valid_d = 1'b0;
		case (state_q)
			ICS_IDLE: begin
				if (req.strobe) begin
					state_d = ICS_SETTLE;
				end
			end
			ICS_SETTLE: begin
				if (!req.strobe) begin
					state_d = ICS_IDLE;
				end else if (hit) begin
					state_d         = ICS_ACK;
					drv_d.ack_n     = 1'b0;
					drv_d.ack_oe_n  = 1'b0;
					if (!req.write) begin
						drv_d.data      = (req.addr == STATUS_ADDR) ? {pend_q, cause_q} : rx_data_q;
						drv_d.data_oe_n = 1'b0;
					end else if (req.addr == DATA_ADDR) begin
						rx_data_d  = req.wdata;
						rx_valid_d = 1'b1;
					end
					if (clr_hit) begin
						pend_d = 1'b0;
					end
				end else begin
					state_d = ICS_IDLE;
				end
			end
			ICS_ACK: begin
				if (!req.strobe) begin
					state_d         = ICS_IDLE;
					drv_d.ack_n     = 1'b1;
					drv_d.ack_oe_n  = 1'b1;
					drv_d.data_oe_n = 1'b1;
				end
			end
			default: state_d = ICS_IDLE;
		endcase
		// A new event beats a clear in the same cycle
		if (event_pulse) begin
			pend_d  = 1'b1;
			cause_d = cause_in;
			if (!pend_q) begin
				line_d = irq_line_sel;
			end
		end
		drv_d.irq_n    = ~({3'h0, pend_d} << line_d);
		drv_d.irq_oe_n = drv_d.irq_n;
	end

	// Channel reset acts within a few cycles, far inside ten microseconds
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_q    <= ICS_IDLE;
			drv_q      <= '1;
			pend_q     <= 1'b0;
			cause_q    <= 7'h00;
			line_q     <= IRQ_LINE_DEF;
			rx_data_q  <= DATA_RST;
			rx_valid_q <= 1'b0;
		end else if (chan_rst) begin
			state_q    <= ICS_IDLE;
			drv_q      <= '1;
			pend_q     <= 1'b0;
			cause_q    <= 7'h00;
			line_q     <= IRQ_LINE_DEF;
			rx_data_q  <= DATA_RST;
			rx_valid_q <= 1'b0;
		end else begin
			state_q    <= state_d;
			drv_q      <= drv_d;
			pend_q     <= pend_d;
			cause_q    <= cause_d;
			line_q     <= line_d;
			rx_data_q  <= rx_data_d;
			rx_valid_q <= rx_valid_d;
		end
	end

	assign xfer_ack_n     = drv_q.ack_n;
	assign xfer_ack_oe_n  = drv_q.ack_oe_n;
	assign byte_lane_out  = drv_q.data;
	assign byte_lane_oe_n = drv_q.data_oe_n;
	assign irq_lines_n    = drv_q.irq_n;
	assign irq_lines_oe_n = drv_q.irq_oe_n;
	assign rx_data        = rx_data_q;
	assign rx_valid       = rx_valid_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_ACK_NEEDS_STROBE: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(xfer_ack_n) |-> $past(req.strobe)) else $error("Ack without strobe");
	AST_ACK_RELEASE: assert property (@(posedge sys_clk) disable iff (rst || chan_rst)
		(state_q == ICS_ACK && !req.strobe) |=> xfer_ack_n) else $error("Ack not released");
	AST_ACK_OWN_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(xfer_ack_n) |-> $past(hit)) else $error("Ack on foreign address");
	AST_ONE_LINE: assert property (@(posedge sys_clk) disable iff (rst)
		$countones(~irq_lines_n) <= 1) else $error("Several lines driven");
	AST_IRQ_HELD: assert property (@(posedge sys_clk) disable iff (rst)
		(pend_q && !chan_rst && !clr_hit) |=> pend_q) else $error("Interrupt dropped");
	AST_RESET_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
		chan_rst |=> (&irq_lines_n && !pend_q)) else $error("Reset did not clear");
	AST_STATUS_READ: assert property (@(posedge sys_clk) disable iff (rst || chan_rst)
		(state_q == ICS_SETTLE && req.strobe && !req.write && req.addr == STATUS_ADDR && !event_pulse)
		|=> byte_lane_out[7] == $past(pend_q)) else $error("Status byte wrong");
	AST_READ_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(req.strobe) && !req.write && req.addr == STATUS_ADDR && clr_mode == ICS_CLR_READ
		|-> ##[1:29] (!pend_q || event_pulse || !req.strobe)) else $error("Read clear late");
	AST_WRITE_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(req.strobe) && req.write && req.addr == WCLR_ADDR && clr_mode == ICS_CLR_WRITE
		|-> ##[1:29] (!pend_q || event_pulse || !req.strobe)) else $error("Write clear late");

endmodule : ics_slave

// ==== rtl/ics_sync.sv ====
// Purpose: Two-flop synchroniser bank for the channel pins
// Assumes: Inputs are asynchronous to sys_clk
// Notes:   Reset value is a parameter so idle-high pins come up inactive
`timescale 1ns/1ps
module ics_sync #(
	parameter int         W         = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         rst,
	// Data
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : ics_sync

// ==== tb/ics_master_model.sv ====
// Purpose: Channel master model driving the slave
// Assumes: Ack line pulled up by the master
// Notes:   Idle read lane shows a toggling pattern
`timescale 1ns/1ps
module ics_master_model (
	// Clock
	input  wire logic       sys_clk,
	// Master drive
	output logic            xfer_strobe_n,
	output logic            write_sel_n,
	output logic            channel_reset_n,
	output logic [11:0]     slave_addr,
	output logic [7:0]      byte_lane,
	// Slave drive
	input  wire logic       xfer_ack_n,
	input  wire logic       xfer_ack_oe_n,
	input  wire logic [7:0] byte_lane_out,
	input  wire logic       byte_lane_oe_n
);
	logic       ack_w;
	logic [7:0] wdata;
	logic [7:0] junk;
	logic       chan_clk;
	assign ack_w = xfer_ack_oe_n | xfer_ack_n;
	assign byte_lane = !write_sel_n ? wdata : (byte_lane_oe_n ? junk : byte_lane_out);
	// Idle lane pattern runs off the channel clock, unrelated to sys_clk
	always @(posedge chan_clk) junk <= ~junk;
	always #125 chan_clk = ~chan_clk;
	initial begin
		chan_clk = 1'b0;
		junk = 8'h5a;
		wdata = 8'h00;
		slave_addr = 12'h000;
		xfer_strobe_n = 1'b1;
		write_sel_n = 1'b1;
		channel_reset_n = 1'b1;
	end
	// One byte transfer; strobe held until ack is seen or 12 cycles pass
	task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
		output logic [7:0] rd, output logic hit);
		int n;
		@(posedge sys_clk) #5;
		slave_addr = a;
		wdata = d;
		write_sel_n = !wr;
		@(posedge sys_clk) #5;
		xfer_strobe_n = 1'b0;
		hit = 1'b0;
		rd = 8'h00;
		for (n = 0; n < 12 && !hit; n++) begin
			@(posedge sys_clk) #1;
			hit = !ack_w;
			rd = byte_lane;
		end
		#4 xfer_strobe_n = 1'b1;
		for (n = 0; n < 12 && !ack_w; n++) begin
			@(posedge sys_clk) #1;
		end
		@(posedge sys_clk) #5;
		write_sel_n = 1'b1;
	endtask : xfer
	task automatic chan_reset(input int len);
		@(posedge sys_clk) #5;
		channel_reset_n = 1'b0;
		repeat (len) @(posedge sys_clk);
		#5 channel_reset_n = 1'b1;
	endtask : chan_reset
endmodule : ics_master_model

// ==== tb/tb_io_channel_slave_interface.sv ====
// Purpose: Self-checking bench for the channel slave
// Assumes: Irq lines pulled up by the master
// Notes:   Release limits are 30 and 100 cycles
`timescale 1ns/1ps
module tb_io_channel_slave_interface;
	import ics_pkg::*;
	logic          sys_clk, rst, xfer_strobe_n, write_sel_n, channel_reset_n, hit;
	logic          xfer_ack_n, xfer_ack_oe_n, byte_lane_oe_n, event_pulse, rx_valid;
	logic [11:0]   slave_addr;
	logic [7:0]    byte_lane_in, byte_lane_out, rx_data, rd;
	logic [3:0]    irq_lines_n, irq_lines_oe_n, irq_w;
	logic [6:0]    cause_in;
	logic [1:0]    irq_line_sel;
	ics_clr_mode_t clr_mode;
	int            error_cnt = 0, samples_checked = 0, cyc = 0, rxv = 0, k;
	assign irq_w = irq_lines_n | irq_lines_oe_n;
	ics_slave DUT (.sys_clk, .rst, .xfer_strobe_n, .write_sel_n, .channel_reset_n, .slave_addr,
		.byte_lane_in, .xfer_ack_n, .xfer_ack_oe_n, .byte_lane_out, .byte_lane_oe_n, .irq_lines_n,
		.irq_lines_oe_n, .event_pulse, .cause_in, .clr_mode, .irq_line_sel, .rx_data, .rx_valid);
	ics_master_model m (.sys_clk, .xfer_strobe_n, .write_sel_n, .channel_reset_n, .slave_addr,
		.byte_lane(byte_lane_in), .xfer_ack_n, .xfer_ack_oe_n, .byte_lane_out, .byte_lane_oe_n);
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc++;
		if (rx_valid === 1'b1)
			rxv++;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop;
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic fire(input logic [1:0] sel, input logic [6:0] c);
		@(posedge sys_clk) #5;
		irq_line_sel = sel;
		cause_in = c;
		event_pulse = 1'b1;
		@(posedge sys_clk) #5;
		event_pulse = 1'b0;
		repeat (3) @(posedge sys_clk);
		#5 chk(irq_w, {4'h0, ~(4'h1 << sel)});
	endtask : fire
	task automatic t_lines;
		for (k = 0; k < 4; k++) begin
			fire(k[1:0], 7'h40 | k[6:0]);
			repeat (50) @(posedge sys_clk);
			chk(irq_w, {4'h0, ~(4'h1 << k[1:0])});
			m.xfer(1'b0, STATUS_ADDR_DEF, 8'h00, rd, hit);
			chk(hit, 1'b1);
			chk(rd, {1'b1, 7'h40 | k[6:0]});
			chk(irq_w, 4'hf);
		end
		$display("lines test done");
	endtask : t_lines
	task automatic t_wclr;
		clr_mode = ICS_CLR_WRITE;
		fire(2'h3, 7'h15);
		m.xfer(1'b0, STATUS_ADDR_DEF, 8'h00, rd, hit);
		chk(rd, 8'h95);
		chk(irq_w, 4'h7);
		m.xfer(1'b1, DATA_ADDR_DEF, 8'ha5, rd, hit);
		chk(rxv[7:0], 8'h01);
		chk(rx_data, 8'ha5);
		m.xfer(1'b0, DATA_ADDR_DEF, 8'h00, rd, hit);
		chk(rd, 8'ha5);
		m.xfer(1'b1, WCLR_ADDR_DEF, 8'h00, rd, hit);
		chk(irq_w, 4'hf);
		m.xfer(1'b0, 12'h800, 8'h00, rd, hit);
		chk(hit, 1'b0);
		$display("write clear test done");
	endtask : t_wclr
	task automatic t_rclr;
		clr_mode = ICS_CLR_RESET;
		fire(2'h1, 7'h2a);
		m.xfer(1'b1, WCLR_ADDR_DEF, 8'h00, rd, hit);
		chk(irq_w, 4'hd);
		fork
			m.chan_reset(100);
			begin
				repeat (100) @(posedge sys_clk);
				#1 chk(irq_w, 4'hf);
			end
		join
		m.xfer(1'b0, STATUS_ADDR_DEF, 8'h00, rd, hit);
		chk(rd, 8'h00);
		$display("reset clear test done");
	endtask : t_rclr
	task automatic report_and_stop;
		$display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop
	initial begin
		rst = 1'b1;
		event_pulse = 1'b0;
		cause_in = 7'h00;
		irq_line_sel = 2'h0;
		clr_mode = ICS_CLR_READ;
		repeat (2) @(posedge sys_clk);
		#5 rst = 1'b0;
		chk({xfer_ack_oe_n, byte_lane_oe_n, irq_w}, 8'h3f);
		t_lines;
		t_wclr;
		t_rclr;
		report_and_stop;
	end
endmodule : tb_io_channel_slave_interface
